/* converter_regs_consts.vh */
// Offsets, field positions and reset values of the converter register bank
`ifndef CONVERTER_REGS_CONSTS_VH
`define CONVERTER_REGS_CONSTS_VH
`define ADDR_CONVERTER_SETUP 4'h0
`define ADDR_CABLE_GAIN_SETUP 4'h1
`define ADDR_CURRENT_LIMIT_SETUP 4'h2
`define ADDR_RETRY_DETECT_SETUP 4'h3
`define ADDR_CONFIGURED_FLAG_SETUP 4'h4
`define ADDR_IRQ_ENABLE_ATTACH 4'h7
`define ADDR_IRQ_ENABLE_BUS_FAULTS 4'h8
`define ADDR_IRQ_ENABLE_THERMAL_OV 4'h9
`define ADDR_IRQ_FLAGS_ATTACH 4'hA
`define ADDR_IRQ_FLAGS_BUS_FAULTS 4'hB
`define ADDR_IRQ_FLAGS_THERMAL_OV 4'hC
`define ADDR_ATTACH_STATE 4'hD
`define BIT_CONVERTER_ENABLE 5
`define BIT_SYNC_DIR 1
`define BIT_SPREAD_EN 0
`define BIT_AUTO_CLEAR 7
`define BIT_SETUP_MISSING 7
`define BIT_ATTACH_STATE 3
`define MASK_CONVERTER_SETUP 8'h23
`define MASK_CABLE_GAIN 8'h1F
`define MASK_CURRENT_LIMIT 8'hD7
`define MASK_RETRY_DETECT 8'hF0
`define MASK_CONFIGURED 8'h01
`define MASK_IRQ_ATTACH 8'h8A
`define MASK_IRQ_BUS 8'h3F
`define MASK_IRQ_THERMAL 8'h0E
`define MASK_FLAGS_ATTACH 8'h0A
`define MASK_FAULT_BUS 8'h3F
`define MASK_FAULT_THERMAL 8'h06
`define RESET_CONVERTER_ENABLE 1'h1
`define RESET_CABLE_GAIN 8'h00
`define RESET_CURRENT_LIMIT 8'h07
`define RESET_RETRY_DETECT 8'h00
`define RESET_CONFIGURED 8'h00
`define RESET_IRQ_ENABLE 8'h00
`define STRAP_SETTLE 2'h2
`endif

/* converter_config_irq_regs.v */
// Configuration and interrupt register bank of the step-down converter
`include "converter_regs_consts.vh"
module converter_config_irq_regs (
  input wire clk,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire buck_enable_pin,
  input wire first_config_resistor_sync,
  input wire first_config_resistor_spread,
  input wire [7:0] attach_events,
  input wire [7:0] bus_fault_events,
  input wire [7:0] thermal_ov_events,
  input wire charger_attach_state,
  output reg buck_run,
  output reg sync_pin_oe,
  output reg spread_enable,
  output reg fault_out,
  output reg fault_oe,
  output reg irq_pending
);
  reg [2:0] buck_pin_sync;
  reg [2:0] attach_sync;
  reg [1:0] strap_sync_a;
  reg [1:0] strap_spread_a;
  reg strap_loaded;
  reg [1:0] strap_wait;
  reg converter_enable_bit;
  reg sync_dir;
  reg spread_bit;
  reg [7:0] cable_gain_setup;
  reg [7:0] current_limit_setup;
  reg [7:0] retry_detect_setup;
  reg [7:0] configured_flag_setup;
  reg [7:0] irq_enable_attach;
  reg [7:0] irq_enable_bus_faults;
  reg [7:0] irq_enable_thermal_ov;
  reg [7:0] irq_flags_attach;
  reg [7:0] irq_flags_bus_faults;
  reg [7:0] irq_flags_thermal_ov;
  reg [7:0] next_rdata;
  wire auto_clear;
  wire setup_missing_flag;
  wire [7:0] bus_set;
  wire [7:0] thermal_set;
  wire [7:0] attach_set;
  wire clear_attach;
  wire clear_bus;
  wire clear_thermal;
  genvar i;

  assign auto_clear = irq_enable_attach[`BIT_AUTO_CLEAR];
  assign setup_missing_flag = ~configured_flag_setup[0];
  assign bus_set = bus_fault_events & `MASK_IRQ_BUS;
  assign thermal_set = thermal_ov_events & `MASK_IRQ_THERMAL;
  assign attach_set = attach_events & `MASK_FLAGS_ATTACH;
  assign clear_attach = reg_rd && auto_clear && (reg_addr == `ADDR_IRQ_FLAGS_ATTACH);
  assign clear_bus = reg_rd && auto_clear && (reg_addr == `ADDR_IRQ_FLAGS_BUS_FAULTS);
  assign clear_thermal = reg_rd && auto_clear && (reg_addr == `ADDR_IRQ_FLAGS_THERMAL_OV);

  // Pin synchronisers
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      buck_pin_sync <= 3'h0;
      attach_sync <= 3'h0;
      strap_sync_a <= 2'h0;
      strap_spread_a <= 2'h0;
    end
    else
    begin
      buck_pin_sync <= {buck_pin_sync[1:0], buck_enable_pin};
      attach_sync <= {attach_sync[1:0], charger_attach_state};
      strap_sync_a <= {strap_sync_a[0], first_config_resistor_sync};
      strap_spread_a <= {strap_spread_a[0], first_config_resistor_spread};
    end
  end

  // Setup registers
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_loaded <= 1'b0;
      strap_wait <= 2'h0;
      converter_enable_bit <= `RESET_CONVERTER_ENABLE;
      sync_dir <= 1'b0;
      spread_bit <= 1'b0;
      cable_gain_setup <= `RESET_CABLE_GAIN;
      current_limit_setup <= `RESET_CURRENT_LIMIT;
      retry_detect_setup <= `RESET_RETRY_DETECT;
      configured_flag_setup <= `RESET_CONFIGURED;
      irq_enable_attach <= `RESET_IRQ_ENABLE;
      irq_enable_bus_faults <= `RESET_IRQ_ENABLE;
      irq_enable_thermal_ov <= `RESET_IRQ_ENABLE;
    end
    else
    begin
      // Wait until the strap synchronisers hold the pin level, then load once
      if (!strap_loaded)
      begin
        if (strap_wait == `STRAP_SETTLE)
        begin
          strap_loaded <= 1'h1;
          sync_dir <= strap_sync_a[1];
          spread_bit <= strap_spread_a[1];
        end
        else
        begin
          strap_wait <= strap_wait + 2'h1;
        end
      end
      if (reg_wr)
      begin
        case (reg_addr)
          `ADDR_CONVERTER_SETUP:
          begin
            converter_enable_bit <= reg_wdata[`BIT_CONVERTER_ENABLE];
            if (strap_loaded)
            begin
              sync_dir <= reg_wdata[`BIT_SYNC_DIR];
              spread_bit <= reg_wdata[`BIT_SPREAD_EN];
            end
          end
          `ADDR_CABLE_GAIN_SETUP: cable_gain_setup <= reg_wdata & `MASK_CABLE_GAIN;
          `ADDR_CURRENT_LIMIT_SETUP: current_limit_setup <= reg_wdata & `MASK_CURRENT_LIMIT;
          `ADDR_RETRY_DETECT_SETUP: retry_detect_setup <= reg_wdata & `MASK_RETRY_DETECT;
          `ADDR_CONFIGURED_FLAG_SETUP: configured_flag_setup <= reg_wdata & `MASK_CONFIGURED;
          `ADDR_IRQ_ENABLE_ATTACH: irq_enable_attach <= reg_wdata & `MASK_IRQ_ATTACH;
          `ADDR_IRQ_ENABLE_BUS_FAULTS: irq_enable_bus_faults <= reg_wdata & `MASK_IRQ_BUS;
          `ADDR_IRQ_ENABLE_THERMAL_OV: irq_enable_thermal_ov <= reg_wdata & `MASK_IRQ_THERMAL;
          default:
          begin
          end
        endcase
      end
    end
  end

  // Sticky flags, one slice per bit: a set in the same cycle wins over a clear
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : flag_bit
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          irq_flags_attach[i] <= 1'h0;
          irq_flags_bus_faults[i] <= 1'h0;
          irq_flags_thermal_ov[i] <= 1'h0;
        end
        else
        begin
          if (attach_set[i])
          begin
            irq_flags_attach[i] <= 1'h1;
          end
          else if (clear_attach)
          begin
            irq_flags_attach[i] <= 1'h0;
          end
          if (bus_set[i])
          begin
            irq_flags_bus_faults[i] <= 1'h1;
          end
          else if (clear_bus)
          begin
            irq_flags_bus_faults[i] <= 1'h0;
          end
          if (thermal_set[i])
          begin
            irq_flags_thermal_ov[i] <= 1'h1;
          end
          else if (clear_thermal)
          begin
            irq_flags_thermal_ov[i] <= 1'h0;
          end
        end
      end
    end
  endgenerate

  // Read mux
  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `ADDR_CONVERTER_SETUP: next_rdata = {2'h0, converter_enable_bit, 3'h0, sync_dir, spread_bit};
      `ADDR_CABLE_GAIN_SETUP: next_rdata = cable_gain_setup;
      `ADDR_CURRENT_LIMIT_SETUP: next_rdata = current_limit_setup;
      `ADDR_RETRY_DETECT_SETUP: next_rdata = retry_detect_setup;
      `ADDR_CONFIGURED_FLAG_SETUP: next_rdata = configured_flag_setup;
      `ADDR_IRQ_ENABLE_ATTACH: next_rdata = irq_enable_attach;
      `ADDR_IRQ_ENABLE_BUS_FAULTS: next_rdata = irq_enable_bus_faults;
      `ADDR_IRQ_ENABLE_THERMAL_OV: next_rdata = irq_enable_thermal_ov;
      `ADDR_IRQ_FLAGS_ATTACH: next_rdata = {setup_missing_flag, irq_flags_attach[6:0]};
      `ADDR_IRQ_FLAGS_BUS_FAULTS: next_rdata = irq_flags_bus_faults;
      `ADDR_IRQ_FLAGS_THERMAL_OV: next_rdata = irq_flags_thermal_ov;
      `ADDR_ATTACH_STATE: next_rdata = {4'h0, attach_sync[2], 3'h0};
      default: next_rdata = 8'h00;
    endcase
  end

  // Outputs
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 8'h00;
      buck_run <= 1'b0;
      sync_pin_oe <= 1'b0;
      spread_enable <= 1'b0;
      fault_out <= 1'b0;
      fault_oe <= 1'b0;
      irq_pending <= 1'b0;
    end
    else
    begin
      if (reg_rd)
        reg_rdata <= next_rdata;
      buck_run <= converter_enable_bit & buck_pin_sync[2];
      sync_pin_oe <= strap_loaded & ~sync_dir;
      spread_enable <= spread_bit;
      fault_out <= 1'b0;
      fault_oe <= |(irq_flags_bus_faults & `MASK_FAULT_BUS) |
        |(irq_flags_thermal_ov & `MASK_FAULT_THERMAL);
      irq_pending <= |(irq_flags_attach & irq_enable_attach & `MASK_FLAGS_ATTACH) |
        |(irq_flags_bus_faults & irq_enable_bus_faults) |
        |(irq_flags_thermal_ov & irq_enable_thermal_ov);
    end
  end
endmodule

/* regs_checker_asserts.sv */
// Concurrent checks on the converter register bank ports
module regs_checker (
  input wire clk,
  input wire rst_b,
  input wire reg_wr,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire buck_enable_pin,
  input wire [7:0] attach_events,
  input wire [7:0] bus_fault_events,
  input wire [7:0] thermal_ov_events,
  input wire buck_run,
  input wire sync_pin_oe,
  input wire spread_enable,
  input wire fault_out,
  input wire fault_oe,
  input wire irq_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire wr0 = reg_wr && reg_addr == 4'h0;
  a_pin_gates_buck: assert property (!buck_enable_pin [*5] |-> !buck_run)
    else $error("buck runs with pin low");
  a_write_stops_buck: assert property (wr0 && !reg_wdata[5] |-> ##2 !buck_run)
    else $error("buck still runs after disable");
  a_write_starts_buck: assert property ((buck_enable_pin [*6] ##0 wr0 && reg_wdata[5])
    |-> ##2 buck_run)
    else $error("buck not running after enable");
  a_sync_dir_write: assert property (wr0 |-> ##2 sync_pin_oe == !$past(reg_wdata[1], 2))
    else $error("sync direction wrong");
  a_spread_write: assert property (wr0 |-> ##2 spread_enable == $past(reg_wdata[0], 2))
    else $error("spread enable wrong");
  a_fault_sets_pin: assert property (bus_fault_events[0] |-> ##[1:3] fault_oe)
    else $error("fault pin not asserted");
  a_fault_level_low: assert property (!fault_out)
    else $error("fault pin drives high");
  a_irq_has_cause: assert property ($rose(irq_pending) |-> $past(reg_wr || (|attach_events)
    || (|bus_fault_events) || (|thermal_ov_events), 2))
    else $error("irq rose without cause");
  c_irq: cover property (irq_pending);
  c_fault: cover property (fault_oe);
  c_stop: cover property ($fell(buck_run));
endmodule
bind converter_config_irq_regs regs_checker chk (.clk, .rst_b, .reg_wr, .reg_addr, .reg_wdata,
  .buck_enable_pin, .attach_events, .bus_fault_events, .thermal_ov_events, .buck_run,
  .sync_pin_oe, .spread_enable, .fault_out, .fault_oe, .irq_pending);

/* host_model.sv */
// Host model driving the register strobes
module host_model (
  input wire clk,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [3:0] reg_addr = 4'h0,
  output logic [7:0] reg_wdata = 8'h00,
  input wire [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released lines show inverted values
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    d = reg_rdata;
  endtask
endmodule

/* converter_config_irq_regs_test.sv */
// Self-checking bench for the converter register bank
module converter_config_irq_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, pin = 1, att = 1, strap_s = 1, strap_p = 0;
  logic [7:0] aev = 8'h00, bev = 8'h00, tev = 8'h00, rd;
  wire reg_wr, reg_rd, buck_run, sync_pin_oe, spread_enable, fault_out, fault_oe, irq_pending;
  wire [3:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata;
  int tests_run = 0, err_total = 0;
  always #10 clk = ~clk;
  host_model host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  converter_config_irq_regs DUT (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .buck_enable_pin(pin), .first_config_resistor_sync(strap_s),
    .first_config_resistor_spread(strap_p), .attach_events(aev), .bus_fault_events(bev),
    .thermal_ov_events(tev), .charger_attach_state(att), .buck_run, .sync_pin_oe,
    .spread_enable, .fault_out, .fault_oe, .irq_pending);
  task tally_and_finish;
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] exp);
    host.rd(a, rd);
    chk(rd, exp);
  endtask
  task wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task outs(input logic [2:0] exp);
    chk({5'h00, buck_run, sync_pin_oe, spread_enable}, {5'h00, exp});
  endtask
  initial
  begin
    #200000;
    err_total++;
    tally_and_finish;
  end
  initial
  begin
    wait_n(8);
    rst_b = 1;
    wait_n(6);
    outs(3'b100);
    rchk(4'h0, 8'h22);
    rchk(4'h2, 8'h07);
    rchk(4'h5, 8'h00);
    rchk(4'hA, 8'h80);
    rchk(4'hD, 8'h08);
    host.wr(4'h1, 8'hFF);
    rchk(4'h1, 8'h1F);
    host.wr(4'hD, 8'h00);
    rchk(4'hD, 8'h08);
    host.wr(4'h0, 8'hFD);
    wait_n(2);
    outs(3'b111);
    rchk(4'h0, 8'h21);
    host.wr(4'h0, 8'h02);
    wait_n(2);
    outs(3'b000);
    host.wr(4'h0, 8'h20);
    pin = 0;
    wait_n(6);
    outs(3'b010);
    pin = 1;
    wait_n(6);
    outs(3'b110);
    tev = 8'h08;
    wait_n(1);
    tev = 8'h00;
    wait_n(2);
    chk({6'h00, irq_pending, fault_oe}, 8'h00);
    rchk(4'hC, 8'h08);
    host.wr(4'h9, 8'h08);
    wait_n(2);
    chk({7'h00, irq_pending}, 8'h01);
    bev = 8'h01;
    wait_n(1);
    bev = 8'h00;
    wait_n(2);
    chk({7'h00, fault_oe}, 8'h01);
    chk({7'h00, fault_out}, 8'h00);
    rchk(4'hB, 8'h01);
    rchk(4'hB, 8'h01);
    host.wr(4'h7, 8'h80);
    rchk(4'hB, 8'h01);
    rchk(4'hB, 8'h00);
    wait_n(2);
    chk({7'h00, fault_oe}, 8'h00);
    rst_b = 0;
    strap_s = 0;
    strap_p = 1;
    wait_n(8);
    rst_b = 1;
    wait_n(6);
    outs(3'b111);
    rchk(4'h0, 8'h21);
    rchk(4'hC, 8'h00);
    tally_and_finish;
  end
endmodule
